/* File: pkg/aic_pkg.sv */
package aic_pkg;
  localparam int NCH = 2;
  localparam int CH_W = 1;
  localparam int AVG_DEPTH = 8;
  localparam int STAT_W = 1 + 4 * NCH;

  // Byte offsets on the register bus
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_STATUS = 6'h04;
  localparam logic [5:0] OFS_IRQ_CLR = 6'h08;
  localparam logic [5:0] OFS_IRQ_EN = 6'h0C;
  localparam logic [5:0] OFS_CH_BASE = 6'h10;
  localparam logic [5:0] OFS_CH_STRIDE = 6'h10;
  localparam logic [5:0] OFS_CH_CFG = 6'h00;
  localparam logic [5:0] OFS_CH_UPR = 6'h04;
  localparam logic [5:0] OFS_CH_LWR = 6'h08;
  localparam logic [5:0] OFS_CH_DATA = 6'h0C;

  // Field positions
  localparam int CTRL_SHORT_EN = 0;
  localparam int CTRL_OVER_EN = 1;
  localparam int CTRL_UNDER_EN = 2;
  localparam int CTRL_FMT_LSB = 4;
  localparam int CFG_RANGE_LSB = 0;
  localparam int CFG_FILTER_LSB = 4;
  localparam int CFG_UPR_EN = 8;
  localparam int CFG_LWR_EN = 9;
  localparam int STAT_SHORT = 0;
  localparam int STAT_CH_LSB = 1;
  localparam int STAT_CH_W = 4;

  // Reset values
  localparam logic RST_SHORT_EN = 1'b1;
  localparam logic RST_OVER_EN = 1'b1;
  localparam logic RST_UNDER_EN = 1'b1;
  localparam logic RST_USER_EN = 1'b0;

  typedef enum logic [2:0] {RNG_PM10V, RNG_PM5V, RNG_PM20MA, RNG_0_10V, RNG_0_5V, RNG_1_5V, RNG_0_20MA,
                            RNG_4_20MA} aic_range_t;
  typedef enum logic [1:0] {FMT_OFFSET, FMT_SIGN_MAG, FMT_TWOS} aic_fmt_t;
  typedef enum logic [1:0] {FLT_NONE, FLT_MEAN_OF_TWO, FLT_MEAN_OF_FOUR, FLT_MEAN_OF_EIGHT} aic_filter_t;

  // Limits per range, in mV for voltage ranges and uA for current ranges
  localparam logic signed [15:0] OVER_LIM [8] = '{16'sh2774, 16'sh13BA, 16'sh4EE8, 16'sh2742, 16'sh13A1,
                                                  16'sh139C, 16'sh4E84, 16'sh4E70};
  localparam logic signed [15:0] UNDER_LIM [8] = '{-16'sh2774, -16'sh13BA, -16'sh4EE8, -16'sh0032, -16'sh0019,
                                                   16'sh03D4, -16'sh0064, 16'sh0F50};
  localparam logic signed [15:0] LWR_MIN [8] = '{-16'sh2904, -16'sh1482, -16'sh5208, 16'sh0000, 16'sh0000,
                                                 16'sh02EE, 16'sh0000, 16'sh0BB8};
  localparam logic signed [15:0] LWR_MAX [8] = '{16'sh28D2, 16'sh1464, 16'sh51A4, 16'sh28D2, 16'sh1464,
                                                 16'sh1464, 16'sh51A4, 16'sh51A4};
  localparam logic signed [15:0] UPR_MIN [8] = '{-16'sh28D2, -16'sh1464, -16'sh51A4, 16'sh0032, 16'sh001E,
                                                 16'sh030C, 16'sh0064, 16'sh0C1C};
  localparam logic signed [15:0] UPR_MAX [8] = '{16'sh2904, 16'sh1482, 16'sh5208, 16'sh2904, 16'sh1482,
                                                 16'sh1482, 16'sh5208, 16'sh5208};
  localparam logic signed [15:0] UPR_RST = 16'sh2904;
  localparam logic signed [15:0] LWR_RST = -16'sh2904;
endpackage

/* File: src/aic_avg.sv */
`timescale 1ns/1ns
module aic_avg (
  input wire logic clk,
  input wire logic rst,
  input wire logic restart,
  input wire logic s_valid,
  input wire logic signed [15:0] s_data,
  input wire aic_pkg::aic_filter_t mode,
  output logic m_valid,
  output logic signed [15:0] m_data
);
  localparam int DEPTH = aic_pkg::AVG_DEPTH;

  logic signed [15:0] hist_r [DEPTH];
  logic signed [15:0] hist_nxt [DEPTH];
  logic [2:0] wp_r, wp_nxt;
  logic [3:0] fill_r, fill_nxt;
  logic pend_r, pend_nxt;
  logic m_valid_r, m_valid_nxt;
  logic signed [15:0] m_data_r, m_data_nxt;

  always_comb begin
    logic signed [18:0] sum;
    logic [2:0] age;
    logic [3:0] n;
    logic [2:0] base;
    sum = '0;
    age = '0;
    n = 4'(4'h1 << mode);
    base = restart ? 3'h0 : wp_r;
    hist_nxt = hist_r;
    wp_nxt = base;
    fill_nxt = restart ? 4'h0 : fill_r;
    pend_nxt = 1'b0;
    if (s_valid) begin
      hist_nxt[base] = s_data;
      wp_nxt = base + 3'h1;
      if (fill_nxt < 4'(DEPTH)) begin
        fill_nxt = fill_nxt + 4'h1;
      end
      pend_nxt = 1'b1;
    end
    // Only the n newest samples count; n is a power of two so the mean is a shift
    for (int i = 0; i < DEPTH; i++) begin
      age = wp_r - 3'h1 - 3'(i);
      if ({1'b0, age} < n) begin
        sum = sum + 19'(hist_r[i]);
      end
    end
    // No output until a full window has been seen since the last restart
    m_valid_nxt = pend_r && !restart && (fill_r >= n);
    m_data_nxt = 16'(sum >>> mode);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        hist_r[i] <= 16'sh0000;
      end
      wp_r <= 3'h0;
      fill_r <= 4'h0;
      pend_r <= 1'b0;
      m_valid_r <= 1'b0;
      m_data_r <= 16'sh0000;
    end else begin
      hist_r <= hist_nxt;
      wp_r <= wp_nxt;
      fill_r <= fill_nxt;
      pend_r <= pend_nxt;
      m_valid_r <= m_valid_nxt;
      m_data_r <= m_data_nxt;
    end
  end

  assign m_valid = m_valid_r;
  assign m_data = m_data_r;

  a_pass_through: assert property (@(posedge clk) disable iff (rst)
    s_valid && !restart && mode == aic_pkg::FLT_NONE ##1 !restart && mode == aic_pkg::FLT_NONE
    |=> m_valid && m_data == $past(s_data, 2))
    else $error("unfiltered sample not passed through");
  a_restart_mute: assert property (@(posedge clk) disable iff (rst)
    restart |=> !m_valid)
    else $error("output after history restart");
  a_window_full: assert property (@(posedge clk) disable iff (rst)
    restart && !s_valid ##1 (mode == aic_pkg::FLT_MEAN_OF_FOUR && !restart)[*3]
    |=> !m_valid)
    else $error("mean emitted before window filled");
  c_mean_eight: cover property (@(posedge clk) disable iff (rst) m_valid && mode == aic_pkg::FLT_MEAN_OF_EIGHT);
endmodule

/* File: src/aic_top.sv */
`timescale 1ns/1ns
module aic_top (
  input wire logic CLK,
  input wire logic RST,
  input wire logic SUPPLY_SHORT,
  input wire logic SAMPLE_VALID,
  input wire logic [aic_pkg::CH_W-1:0] SAMPLE_CH,
  input wire logic signed [15:0] SAMPLE_DATA,
  input wire logic [5:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  output logic IRQ
);
  localparam int NCH = aic_pkg::NCH;
  localparam int SW = aic_pkg::STAT_W;

  logic short_meta_r, short_sync_r;
  logic wait_r, wait_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic short_en_r, short_en_nxt, over_en_r, over_en_nxt, under_en_r, under_en_nxt;
  aic_pkg::aic_fmt_t fmt_r, fmt_nxt;
  aic_pkg::aic_range_t rng_r [NCH];
  aic_pkg::aic_range_t rng_nxt [NCH];
  aic_pkg::aic_filter_t flt_r [NCH];
  aic_pkg::aic_filter_t flt_nxt [NCH];
  logic [NCH-1:0] upr_en_r, upr_en_nxt, lwr_en_r, lwr_en_nxt, restart;
  logic signed [15:0] upr_r [NCH];
  logic signed [15:0] upr_nxt [NCH];
  logic signed [15:0] lwr_r [NCH];
  logic signed [15:0] lwr_nxt [NCH];
  logic [SW-1:0] irq_en_r, irq_en_nxt, irq_clr;
  logic [NCH-1:0] avg_v;
  logic signed [15:0] avg_d [NCH];
  logic [15:0] data_r [NCH];
  logic [15:0] data_nxt [NCH];
  logic [3:0] err_r [NCH];
  logic [3:0] err_nxt [NCH];
  logic short_err_r, short_err_nxt;
  logic [SW-1:0] status_r, status_nxt;
  logic irq_r, irq_nxt;

  function automatic logic [31:0] aic_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic signed [15:0] aic_clamp(input logic signed [15:0] v, input logic signed [15:0] lo,
                                                  input logic signed [15:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  function automatic logic [15:0] aic_encode(input logic signed [15:0] v, input aic_pkg::aic_fmt_t f);
    logic [15:0] mag;
    mag = v[15] ? 16'(-v) : 16'(v);
    unique case (f)
      aic_pkg::FMT_SIGN_MAG: return {v[15], mag[14:0]};
      aic_pkg::FMT_TWOS: return v;
      default: return {~v[15], v[14:0]};
    endcase
  endfunction

  // The supply-short pin is asynchronous to CLK
  always_ff @(posedge CLK) begin
    if (RST) begin
      short_meta_r <= 1'b0;
      short_sync_r <= 1'b0;
    end else begin
      short_meta_r <= SUPPLY_SHORT;
      short_sync_r <= short_meta_r;
    end
  end

  // Bus slave and configuration
  always_comb begin
    logic [31:0] img;
    logic [31:0] wv;
    logic [5:0] cbase;
    aic_pkg::aic_range_t rn;
    aic_pkg::aic_filter_t fn;
    img = '0;
    wv = '0;
    cbase = '0;
    rn = aic_pkg::RNG_PM10V;
    fn = aic_pkg::FLT_NONE;
    // Every request waits exactly one cycle, so the read image can be registered
    wait_nxt = wait_r ? !(AVS_READ || AVS_WRITE) : 1'b1;
    short_en_nxt = short_en_r;
    over_en_nxt = over_en_r;
    under_en_nxt = under_en_r;
    fmt_nxt = fmt_r;
    irq_en_nxt = irq_en_r;
    irq_clr = '0;
    rng_nxt = rng_r;
    flt_nxt = flt_r;
    upr_en_nxt = upr_en_r;
    lwr_en_nxt = lwr_en_r;
    upr_nxt = upr_r;
    lwr_nxt = lwr_r;
    restart = '0;
    case (AVS_ADDRESS)
      aic_pkg::OFS_CTRL: img = {26'h0, fmt_r, 1'b0, under_en_r, over_en_r, short_en_r};
      aic_pkg::OFS_STATUS: img = 32'(status_r);
      aic_pkg::OFS_IRQ_EN: img = 32'(irq_en_r);
      default: img = '0;
    endcase
    for (int c = 0; c < NCH; c++) begin
      cbase = 6'(aic_pkg::OFS_CH_BASE + 6'(c) * aic_pkg::OFS_CH_STRIDE);
      case (AVS_ADDRESS - cbase)
        aic_pkg::OFS_CH_CFG: img = {22'h0, lwr_en_r[c], upr_en_r[c], 2'h0, flt_r[c], 1'b0, rng_r[c]};
        aic_pkg::OFS_CH_UPR: img = {16'h0, upr_r[c]};
        aic_pkg::OFS_CH_LWR: img = {16'h0, lwr_r[c]};
        aic_pkg::OFS_CH_DATA: img = {12'h0, err_r[c], data_r[c]};
        default: ;
      endcase
    end
    rdata_nxt = (wait_r && AVS_READ) ? img : rdata_r;
    wv = aic_merge(img, AVS_WRITEDATA, AVS_BYTEENABLE);
    if (AVS_WRITE && !wait_r) begin
      case (AVS_ADDRESS)
        aic_pkg::OFS_CTRL: begin
          short_en_nxt = wv[aic_pkg::CTRL_SHORT_EN];
          over_en_nxt = wv[aic_pkg::CTRL_OVER_EN];
          under_en_nxt = wv[aic_pkg::CTRL_UNDER_EN];
          fmt_nxt = aic_pkg::aic_fmt_t'(wv[aic_pkg::CTRL_FMT_LSB +: 2]);
        end
        aic_pkg::OFS_IRQ_CLR: irq_clr = wv[SW-1:0];
        aic_pkg::OFS_IRQ_EN: irq_en_nxt = wv[SW-1:0];
        default: ;
      endcase
      for (int c = 0; c < NCH; c++) begin
        cbase = 6'(aic_pkg::OFS_CH_BASE + 6'(c) * aic_pkg::OFS_CH_STRIDE);
        case (AVS_ADDRESS - cbase)
          aic_pkg::OFS_CH_CFG: begin
            rn = aic_pkg::aic_range_t'(wv[aic_pkg::CFG_RANGE_LSB +: 3]);
            fn = aic_pkg::aic_filter_t'(wv[aic_pkg::CFG_FILTER_LSB +: 2]);
            rng_nxt[c] = rn;
            flt_nxt[c] = fn;
            upr_en_nxt[c] = wv[aic_pkg::CFG_UPR_EN];
            lwr_en_nxt[c] = wv[aic_pkg::CFG_LWR_EN];
            restart[c] = (rn != rng_r[c]) || (fn != flt_r[c]);
            // A range change pulls stale thresholds into the new limits
            upr_nxt[c] = aic_clamp(upr_r[c], aic_pkg::UPR_MIN[rn], aic_pkg::UPR_MAX[rn]);
            lwr_nxt[c] = aic_clamp(lwr_r[c], aic_pkg::LWR_MIN[rn], aic_pkg::LWR_MAX[rn]);
          end
          aic_pkg::OFS_CH_UPR: upr_nxt[c] = aic_clamp(wv[15:0], aic_pkg::UPR_MIN[rng_r[c]],
                                                      aic_pkg::UPR_MAX[rng_r[c]]);
          aic_pkg::OFS_CH_LWR: lwr_nxt[c] = aic_clamp(wv[15:0], aic_pkg::LWR_MIN[rng_r[c]],
                                                      aic_pkg::LWR_MAX[rng_r[c]]);
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      wait_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
      short_en_r <= aic_pkg::RST_SHORT_EN;
      over_en_r <= aic_pkg::RST_OVER_EN;
      under_en_r <= aic_pkg::RST_UNDER_EN;
      fmt_r <= aic_pkg::FMT_OFFSET;
      irq_en_r <= '0;
      upr_en_r <= {NCH{aic_pkg::RST_USER_EN}};
      lwr_en_r <= {NCH{aic_pkg::RST_USER_EN}};
      for (int c = 0; c < NCH; c++) begin
        rng_r[c] <= aic_pkg::RNG_PM10V;
        flt_r[c] <= aic_pkg::FLT_NONE;
        upr_r[c] <= aic_pkg::UPR_RST;
        lwr_r[c] <= aic_pkg::LWR_RST;
      end
    end else begin
      wait_r <= wait_nxt;
      rdata_r <= rdata_nxt;
      short_en_r <= short_en_nxt;
      over_en_r <= over_en_nxt;
      under_en_r <= under_en_nxt;
      fmt_r <= fmt_nxt;
      irq_en_r <= irq_en_nxt;
      upr_en_r <= upr_en_nxt;
      lwr_en_r <= lwr_en_nxt;
      rng_r <= rng_nxt;
      flt_r <= flt_nxt;
      upr_r <= upr_nxt;
      lwr_r <= lwr_nxt;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      aic_avg u_avg (
        .clk(CLK),
        .rst(RST),
        .restart(restart[g]),
        .s_valid(SAMPLE_VALID && (SAMPLE_CH == aic_pkg::CH_W'(g))),
        .s_data(SAMPLE_DATA),
        .mode(flt_r[g]),
        .m_valid(avg_v[g]),
        .m_data(avg_d[g])
      );
    end
  endgenerate

  // Checks, encoding and event status
  always_comb begin
    logic [SW-1:0] ev;
    logic signed [15:0] a;
    ev = '0;
    a = '0;
    for (int c = 0; c < NCH; c++) begin
      // Disabling a check drops its error at once rather than on the next sample
      err_nxt[c] = err_r[c] & {lwr_en_r[c], upr_en_r[c], under_en_r, over_en_r};
      data_nxt[c] = data_r[c];
      if (avg_v[c]) begin
        a = avg_d[c];
        err_nxt[c][0] = over_en_r && (a > aic_pkg::OVER_LIM[rng_r[c]]);
        err_nxt[c][1] = under_en_r && (a < aic_pkg::UNDER_LIM[rng_r[c]]);
        err_nxt[c][2] = upr_en_r[c] && (a > upr_r[c]);
        err_nxt[c][3] = lwr_en_r[c] && (a < lwr_r[c]);
        data_nxt[c] = aic_encode(a, fmt_r);
      end
      ev[aic_pkg::STAT_CH_LSB + aic_pkg::STAT_CH_W * c +: aic_pkg::STAT_CH_W] = err_nxt[c] & ~err_r[c];
    end
    short_err_nxt = short_en_r && short_sync_r;
    ev[aic_pkg::STAT_SHORT] = short_err_nxt && !short_err_r;
    // A new event outweighs a clear written in the same cycle
    status_nxt = (status_r & ~irq_clr) | ev;
    irq_nxt = |(status_nxt & irq_en_nxt);
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      short_err_r <= 1'b0;
      status_r <= '0;
      irq_r <= 1'b0;
      for (int c = 0; c < NCH; c++) begin
        data_r[c] <= 16'h0000;
        err_r[c] <= 4'h0;
      end
    end else begin
      short_err_r <= short_err_nxt;
      status_r <= status_nxt;
      irq_r <= irq_nxt;
      data_r <= data_nxt;
      err_r <= err_nxt;
    end
  end

  assign AVS_READDATA = rdata_r;
  assign AVS_WAITREQUEST = wait_r;
  assign IRQ = irq_r;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  a_short_raise: assert property (short_en_r && short_sync_r && !short_err_r |=> short_err_r && status_r[0])
    else $error("supply short not raised");
  a_short_masked: assert property (!short_en_r |=> !short_err_r)
    else $error("supply short raised while disabled");
  a_range_default: assert property ($past(RST)
    |-> rng_r[0] == aic_pkg::RNG_PM10V && flt_r[0] == aic_pkg::FLT_NONE)
    else $error("wrong range or filter after reset");
  a_format_twos: assert property (avg_v[0] && fmt_r == aic_pkg::FMT_TWOS |=> data_r[0] == $past(avg_d[0]))
    else $error("two's complement value wrong");
  a_format_offset: assert property (avg_v[0] && fmt_r == aic_pkg::FMT_OFFSET
    |=> data_r[0] == ($past(avg_d[0]) ^ 16'h8000))
    else $error("offset binary value wrong");
  a_over_flag: assert property (avg_v[0] && over_en_r && avg_d[0] > aic_pkg::OVER_LIM[rng_r[0]] |=> err_r[0][0])
    else $error("over-range not flagged");
  a_under_flag: assert property (avg_v[0] && avg_d[0] >= aic_pkg::UNDER_LIM[rng_r[0]] |=> !err_r[0][1])
    else $error("under-range flagged inside range");
  a_upper_off: assert property (!upr_en_r[0] |=> !err_r[0][2])
    else $error("upper threshold error while disabled");
  a_thresh_bound: assert property (upr_r[0] <= aic_pkg::UPR_MAX[rng_r[0]] && upr_r[0] >= aic_pkg::UPR_MIN[rng_r[0]]
    && lwr_r[0] <= aic_pkg::LWR_MAX[rng_r[0]] && lwr_r[0] >= aic_pkg::LWR_MIN[rng_r[0]])
    else $error("threshold outside range limits");
  a_bus_answer: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
    else $error("bus answer not one cycle");

  c_over_err: cover property (avg_v[0] ##1 err_r[0][0]);
  c_irq_high: cover property ($rose(IRQ));
  c_restart: cover property (restart[0]);
  c_upper_err: cover property (err_r[0][2]);
endmodule

/* File: dv/aic_sample_src.sv */
`timescale 1ns/1ns
module aic_sample_src (
  input wire logic clk,
  output logic sample_valid,
  output logic sample_ch,
  output logic signed [15:0] sample_data,
  output logic supply_short
);
  // Off the strobe the data lines carry the inverse of the last word, so stale capture cannot pass by luck
  initial begin
    sample_valid = 1'b0;
    sample_ch = 1'b0;
    sample_data = 16'h5a5a;
    supply_short = 1'b0;
  end
  task automatic send(input logic c, input logic signed [15:0] v);
    @(posedge clk);
    sample_valid <= 1'b1;
    sample_ch <= c;
    sample_data <= v;
    @(posedge clk);
    sample_valid <= 1'b0;
    sample_ch <= ~c;
    sample_data <= ~v;
  endtask
  task automatic set_short(input logic s);
    @(posedge clk);
    supply_short <= s;
  endtask
endmodule

/* File: dv/testbench.sv */
`timescale 1ns/1ns
module testbench;
  localparam logic [5:0] CTRL = aic_pkg::OFS_CTRL;
  localparam logic [5:0] STAT = aic_pkg::OFS_STATUS;
  localparam logic [5:0] CLR = aic_pkg::OFS_IRQ_CLR;
  localparam logic [5:0] IEN = aic_pkg::OFS_IRQ_EN;
  localparam logic [5:0] CFG0 = aic_pkg::OFS_CH_BASE + aic_pkg::OFS_CH_CFG;
  localparam logic [5:0] UPR0 = aic_pkg::OFS_CH_BASE + aic_pkg::OFS_CH_UPR;
  localparam logic [5:0] LWR0 = aic_pkg::OFS_CH_BASE + aic_pkg::OFS_CH_LWR;
  localparam logic [5:0] D0 = aic_pkg::OFS_CH_BASE + aic_pkg::OFS_CH_DATA;
  localparam logic [5:0] D1 = D0 + aic_pkg::OFS_CH_STRIDE;
  localparam logic [31:0] LO = 32'h0000_ffff;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic irq;
  logic sample_valid;
  logic sample_ch;
  logic signed [15:0] sample_data;
  logic supply_short;
  int n_mismatch = 0;
  int compares = 0;
  always #50 clk = ~clk;
  aic_top dut_u (.CLK(clk), .RST(rst), .SUPPLY_SHORT(supply_short), .SAMPLE_VALID(sample_valid),
    .SAMPLE_CH(sample_ch), .SAMPLE_DATA(sample_data), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
    .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(avs_byteenable),
    .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest), .IRQ(irq));
  aic_sample_src src_u (.clk(clk), .sample_valid(sample_valid), .sample_ch(sample_ch),
    .sample_data(sample_data), .supply_short(supply_short));
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Request stays up until waitrequest is seen low; the bound catches a slave that never answers
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
    int i;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (i == 20) begin
      n_mismatch++;
      $display("ERROR at %0t: bus timeout got %h expected %h", $time, 1'b1, 1'b0);
      report_and_stop();
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] exp, input logic [31:0] m = 32'hffff_ffff);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    check(q & m, exp);
  endtask
  task automatic samp(input logic signed [15:0] v);
    src_u.send(1'b0, v);
    repeat (4) @(posedge clk);
  endtask
  logic [15:0] enc [4] = '{16'h7c18, 16'h83e8, 16'hfc18, 16'h7c18};
  int sum;
  logic [15:0] e;
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(CTRL, 32'h0000_0007);
    rd(STAT, 32'h0000_0000);
    rd(IEN, 32'h0000_0000);
    rd(CFG0, 32'h0000_0000);
    rd(UPR0, 32'h0000_2904);
    rd(LWR0, 32'h0000_d6fc);
    wr(6'h30, 32'hffff_ffff);
    rd(6'h30, 32'h0000_0000);
    $display("test reset done");
    for (int f = 0; f < 4; f++) begin
      wr(CTRL, 32'h0000_0007 | (f << 4));
      samp(-16'sd1000);
      rd(D0, {16'h0000, enc[f]}, LO);
    end
    wr(CTRL, 32'h0000_0027);
    $display("test format done");
    samp(16'sd5);
    e = 16'h0005;
    for (int f = 0; f < 4; f++) begin
      wr(CFG0, f << 4);
      sum = 0;
      for (int k = 0; k < (1 << f); k++) begin
        samp(16'(7 * k + 10 * f + 1));
        sum += 7 * k + 10 * f + 1;
        if (k < (1 << f) - 1) rd(D0, {16'h0000, e}, LO);
      end
      e = 16'(sum >> f);
      rd(D0, {16'h0000, e}, LO);
    end
    $display("test filter done");
    for (int r = 0; r < 8; r++) begin
      wr(CFG0, r);
      samp(aic_pkg::OVER_LIM[r] + 16'sd1);
      rd(D0, 32'h0001_0000, 32'h0003_0000);
      samp(aic_pkg::OVER_LIM[r]);
      rd(D0, 32'h0000_0000, 32'h0003_0000);
      samp(aic_pkg::UNDER_LIM[r] - 16'sd1);
      rd(D0, 32'h0002_0000, 32'h0003_0000);
      samp(aic_pkg::UNDER_LIM[r]);
      rd(D0, 32'h0000_0000, 32'h0003_0000);
    end
    wr(CFG0, 32'h0000_0000);
    samp(16'sd20000);
    wr(CTRL, 32'h0000_0025);
    rd(D0, 32'h0000_0000, 32'h0001_0000);
    wr(CTRL, 32'h0000_0027);
    $display("test range done");
    wr(UPR0, 32'h0000_03e8);
    wr(LWR0, 32'h0000_fc18);
    wr(CFG0, 32'h0000_0300);
    samp(16'sd1001);
    rd(D0, 32'h0004_0000, 32'h000c_0000);
    samp(16'sd1000);
    rd(D0, 32'h0000_0000, 32'h000c_0000);
    samp(-16'sd1001);
    rd(D0, 32'h0008_0000, 32'h000c_0000);
    wr(UPR0, 32'h0000_7fff);
    rd(UPR0, 32'h0000_2904);
    wr(UPR0, 32'h0000_03e8);
    wr(CFG0, 32'h0000_0007);
    rd(UPR0, 32'h0000_0c1c);
    rd(LWR0, 32'h0000_0bb8);
    avs_byteenable <= 4'h1;
    wr(UPR0, 32'h0000_00ff);
    avs_byteenable <= 4'hf;
    rd(UPR0, 32'h0000_0cff);
    src_u.send(1'b1, 16'sd1234);
    repeat (4) @(posedge clk);
    rd(D1, 32'h0000_04d2, LO);
    $display("test threshold done");
    wr(CFG0, 32'h0000_0000);
    wr(CLR, 32'h0000_01ff);
    rd(STAT, 32'h0000_0000);
    rd(CLR, 32'h0000_0000);
    samp(16'sd20000);
    rd(STAT, 32'h0000_0002);
    check({31'h0, irq}, 32'h0000_0000);
    wr(IEN, 32'h0000_0002);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h0000_0001);
    wr(STAT, 32'h0000_0000);
    rd(STAT, 32'h0000_0002);
    wr(CLR, 32'h0000_0002);
    repeat (2) @(posedge clk);
    rd(STAT, 32'h0000_0000);
    check({31'h0, irq}, 32'h0000_0000);
    $display("test irq done");
    src_u.set_short(1'b1);
    repeat (5) @(posedge clk);
    rd(STAT, 32'h0000_0001, 32'h0000_0001);
    src_u.set_short(1'b0);
    wr(CTRL, 32'h0000_0026);
    wr(CLR, 32'h0000_0001);
    src_u.set_short(1'b1);
    repeat (5) @(posedge clk);
    rd(STAT, 32'h0000_0000, 32'h0000_0001);
    src_u.set_short(1'b0);
    $display("test short done");
    report_and_stop();
  end
endmodule
